// >>> design/tss_pkg.sv
// shared constants and types for the temperature sensor serial slave
package tss_pkg;
  // pointer values that select an internal register
  localparam logic [2:0] PTR_TEMP = 3'h0;
  localparam logic [2:0] PTR_CFG = 3'h1;
  localparam logic [2:0] PTR_HYST = 3'h2;
  localparam logic [2:0] PTR_LOW = 3'h3;
  localparam logic [2:0] PTR_HIGH = 3'h4;
  localparam logic [2:0] PTR_RESET = 3'h0;
  // configuration field positions and reset value
  localparam int CFG_SHUTDOWN_BIT = 0;
  localparam int CFG_FAULTQ_BIT = 4;
  localparam int CFG_TMO_DIS_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // other reset values
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] HYST_RESET = 16'h0000;
  localparam logic [15:0] LOW_RESET = 16'h0000;
  localparam logic [15:0] HIGH_RESET = 16'h0000;
  // fixed high-order slave address bits, strap bits replace the low ones
  localparam logic [6:0] ADDR_BASE = 7'h48;
  // serial field sizes
  localparam int ADDR_BITS = 7;
  localparam int BYTE_BITS = 8;
  localparam int TEMP_BITS = 13;
  // timing
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int CONV_TIME_MS = 500;
  localparam int TMO_MIN_MS = 25;
  localparam int TMO_MAX_MS = 48;
  localparam int CONV_CYCLES = CONV_TIME_MS * CLK_FREQ_KHZ;
  localparam int TMO_CYCLES = TMO_MIN_MS * CLK_FREQ_KHZ;
  localparam int TMO_MAX_CYCLES = TMO_MAX_MS * CLK_FREQ_KHZ;
  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_ACK_RX,
    ST_RDATA,
    ST_ACK_TX
  } tss_state_t;
endpackage

// >>> design/tss_slave.sv
// two-wire slave and register front end of the die temperature sensor
`timescale 1ns/100ps
module tss_slave #(
  parameter int NUM_STRAPS = 4,
  parameter int ALARM_VARIANT = 0,
  parameter int CONV_CYCLES = tss_pkg::CONV_CYCLES,
  parameter int TMO_CYCLES = tss_pkg::TMO_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic addr_strap_bit3,
  input wire logic [tss_pkg::TEMP_BITS-1:0] conv_result,
  input wire logic [1:0] alarm_status,
  input wire logic alarm_req,
  output logic alarm_out,
  output logic alarm_oe_n,
  output logic conv_start,
  output logic conv_abort,
  output logic cfg_shutdown,
  output logic cfg_fault_queue,
  output logic cfg_timeout_dis,
  output logic [15:0] upper_limit,
  output logic [15:0] lower_limit,
  output logic [15:0] hysteresis
);
  import tss_pkg::*;

  generate
    if (NUM_STRAPS < 2 || NUM_STRAPS > 4) begin : g_bad_straps
      $error("NUM_STRAPS must be 2, 3 or 4");
    end
    if (ALARM_VARIANT < 0 || ALARM_VARIANT > 1) begin : g_bad_variant
      $error("ALARM_VARIANT must be 0 or 1");
    end
    if (CONV_CYCLES < 2 || TMO_CYCLES < 2 || TMO_CYCLES > TMO_MAX_CYCLES) begin : g_bad_time
      $error("timing counts out of range");
    end
  endgenerate

  // reset release through two flops
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // pin synchronisers; the first stage feeds only the second
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic scl_d;
  logic sda_d;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 6'h3F;
      pin_sync <= 6'h3F;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      pin_meta <= {addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
                   sda_in, scl_in};
      pin_sync <= pin_meta;
      scl_d <= pin_sync[0];
      sda_d <= pin_sync[1];
    end
  end

  wire scl_s = pin_sync[0];
  wire sda_s = pin_sync[1];
  wire [3:0] straps = pin_sync[5:2];
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_ev = scl_s && scl_d && sda_d && !sda_s;
  wire stop_ev = scl_s && scl_d && !sda_d && sda_s;

  tss_state_t state;
  tss_state_t ack_next;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic bidx;
  logic armed;
  logic [15:0] tx_word;
  logic [2:0] ptr;
  logic [7:0] config_reg;
  logic [15:0] temp_reading;
  logic [15:0] thr [3];
  logic [31:0] tmo_cnt;
  logic [31:0] conv_cnt;

  // address match: straps form the low bits, the rest is fixed
  wire [7:0] rx_byte = {sh[6:0], sda_s};
  wire [6:0] strap_mask = 7'((1 << NUM_STRAPS) - 1);
  wire [6:0] my_addr = (ADDR_BASE & ~strap_mask) | ({3'h0, straps} & strap_mask);
  wire addr_hit = rx_byte[7:1] == my_addr;
  wire byte_end = scl_rise && cnt == 4'h7;
  wire rd_req = state == ST_ADDR && byte_end && addr_hit && sda_s;
  wire cmd_ev = state == ST_CMD && byte_end;
  wire data_ev = state == ST_WDATA && byte_end;
  wire tmo_hit = tmo_cnt == 32'(TMO_CYCLES - 1);
  wire conv_done = conv_cnt == 32'(CONV_CYCLES - 1);
  wire temp_abort = rd_req && ptr == PTR_TEMP;
  wire has_alarm = ALARM_VARIANT == 1;
  wire thr_sel = has_alarm && ptr >= PTR_HYST && ptr <= PTR_HIGH;
  wire [1:0] thr_idx = 2'(ptr - PTR_HYST);
  // unknown pointers read as zero
  wire [15:0] rd_word = ptr == PTR_TEMP ? temp_reading :
                        ptr == PTR_CFG ? {config_reg, 8'h00} :
                        thr_sel ? thr[thr_idx] : 16'h0000;
  wire [7:0] tx_byte = bidx ? tx_word[7:0] : tx_word[15:8];
  wire tx_bit = tx_byte[3'(4'h7 - cnt)];

  // serial engine; only slave behaviour exists here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      ack_next <= ST_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      bidx <= 1'b0;
      armed <= 1'b0;
      tx_word <= 16'h0000;
      sda_oe_n <= 1'b1;
    end else if (start_ev) begin
      state <= ST_ADDR;
      cnt <= 4'h0;
      bidx <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (stop_ev || tmo_hit) begin
      state <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            sh <= rx_byte;
            cnt <= cnt + 4'h1;
          end
          if (byte_end) begin
            cnt <= 4'h0;
            armed <= 1'b0;
            if (state == ST_ADDR && !addr_hit) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_ACK_RX;
            end
            if (state == ST_ADDR) begin
              ack_next <= sda_s ? ST_RDATA : ST_CMD;
              tx_word <= rd_word;
            end else begin
              ack_next <= ST_WDATA;
            end
            if (state == ST_WDATA) begin
              bidx <= 1'b1;
            end
          end
        end
        ST_ACK_RX: begin
          if (scl_fall) begin
            armed <= 1'b1;
            if (!armed) begin
              sda_oe_n <= 1'b0;
            end else begin
              state <= ack_next;
              sda_oe_n <= ack_next == ST_RDATA ? tx_word[15] : 1'b1;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end
          if (scl_fall) begin
            if (cnt == 4'h8) begin
              sda_oe_n <= 1'b1;
              state <= ST_ACK_TX;
            end else begin
              sda_oe_n <= tx_bit;
            end
          end
        end
        ST_ACK_TX: begin
          if (scl_rise) begin
            cnt <= 4'h0;
            bidx <= 1'b1;
            state <= sda_s ? ST_IDLE : ST_RDATA;
          end
        end
      endcase
    end
  end

  // pointer and writable registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= PTR_RESET;
      config_reg <= CFG_RESET;
    end else begin
      if (cmd_ev) begin
        ptr <= rx_byte[2:0];
      end
      if (data_ev && !bidx && ptr == PTR_CFG) begin
        config_reg <= rx_byte;
      end
    end
  end

  localparam logic [15:0] THR_RESET [3] = '{HYST_RESET, LOW_RESET, HIGH_RESET};
  generate
    for (genvar i = 0; i < 3; i++) begin : g_thr
      wire hit = data_ev && thr_sel && thr_idx == 2'(i);
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          thr[i] <= THR_RESET[i];
        end else if (hit && !bidx) begin
          thr[i][15:8] <= rx_byte;
        end else if (hit) begin
          thr[i][7:0] <= rx_byte;
        end
      end
    end
  endgenerate

  // bus stall timer runs while the clock is held low mid-transfer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_cnt <= 32'h0;
    end else if (state == ST_IDLE || scl_s || config_reg[CFG_TMO_DIS_BIT] || tmo_hit) begin
      tmo_cnt <= 32'h0;
    end else begin
      tmo_cnt <= tmo_cnt + 32'h1;
    end
  end

  // conversion pacing; shutdown halts it, a temperature read restarts it
  wire [2:0] low_bits = has_alarm ? {1'b0, alarm_status} : 3'h0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt <= 32'h0;
      temp_reading <= TEMP_RESET;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      conv_start <= conv_done && !temp_abort && !config_reg[CFG_SHUTDOWN_BIT];
      conv_abort <= temp_abort;
      if (config_reg[CFG_SHUTDOWN_BIT] || temp_abort || conv_done) begin
        conv_cnt <= 32'h0;
      end else begin
        conv_cnt <= conv_cnt + 32'h1;
      end
      if (conv_done && !temp_abort && !config_reg[CFG_SHUTDOWN_BIT]) begin
        temp_reading <= {conv_result, low_bits};
      end
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      alarm_out <= 1'b0;
      alarm_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      alarm_out <= 1'b0;
      alarm_oe_n <= !(has_alarm && alarm_req);
    end
  end

  assign cfg_shutdown = config_reg[CFG_SHUTDOWN_BIT];
  assign cfg_fault_queue = config_reg[CFG_FAULTQ_BIT];
  assign cfg_timeout_dis = config_reg[CFG_TMO_DIS_BIT];
  assign hysteresis = thr[0];
  assign lower_limit = thr[1];
  assign upper_limit = thr[2];
endmodule

// >>> verif/tss_sva.sv
// assertion checker for the sensor serial slave
`timescale 1ns/100ps
module tss_sva #(
  parameter int CONV_CYCLES = 200
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic alarm_req,
  input wire logic alarm_out,
  input wire logic alarm_oe_n,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic cfg_shutdown
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // cycles since the last conversion event; slack covers the reset synchroniser
  int gap;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gap <= 0;
    end else begin
      gap <= (conv_start || conv_abort || cfg_shutdown) ? 0 : gap + 1;
    end
  end
  a_sda_low_only: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_alarm_low_only: assert property (alarm_out == 1'b0)
    else $error("alarm pin driven high");
  a_alarm_pulls: assert property (alarm_req [*3] |-> !alarm_oe_n)
    else $error("alarm pin not pulled");
  a_alarm_frees: assert property (!alarm_req [*3] |-> alarm_oe_n)
    else $error("alarm pin not released");
  a_conv_period: assert property (gap <= CONV_CYCLES + 4)
    else $error("conversion period overrun");
  a_abort_single: assert property (conv_abort |=> !conv_abort)
    else $error("abort longer than one cycle");
  a_abort_restart: assert property (conv_abort |=> !conv_start [*8])
    else $error("period not restarted by abort");
  a_sda_steady: assert property (scl_in [*3] |-> $stable(sda_oe_n))
    else $error("data pin moved while clock high");
  c_abort: cover property (conv_abort);
  c_ack: cover property (!sda_oe_n);
  c_alarm: cover property (!alarm_oe_n);
endmodule
bind tss_slave tss_sva #(.CONV_CYCLES(CONV_CYCLES)) sva_u (
  .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .alarm_req(alarm_req), .alarm_out(alarm_out),
  .alarm_oe_n(alarm_oe_n), .conv_start(conv_start), .conv_abort(conv_abort),
  .cfg_shutdown(cfg_shutdown));

// >>> verif/tss_master.sv
// bus master model for the two-wire link
`timescale 1ns/100ps
module tss_master (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // long setup so a slave acknowledge is gone before the clock rises
  task automatic start();
    sda_drv = 1'b1;
    #48 scl = 1'b1;
    #32 sda_drv = 1'b0;
    #32 scl = 1'b0;
  endtask
  task automatic stop();
    #16 sda_drv = 1'b0;
    #16 scl = 1'b1;
    #32 sda_drv = 1'b1;
    #64;
  endtask
  // eight data bits then the acknowledge slot, msb first
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #16 sda_drv = tx[i];
      #16 scl = 1'b1;
      #30 rx[i] = sda;
      #2 scl = 1'b0;
    end
  endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the sensor serial slave
`timescale 1ns/100ps
module testbench;
  import tss_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] strap = 4'h5;
  logic [12:0] conv_result = 13'h1ABC;
  logic [1:0] alarm_status = 2'h2;
  logic alarm_req = 1'b0;
  logic [8:0] rx;
  logic [15:0] q;
  wire scl, m_sda, sda_out, sda_oe_n, alarm_out, alarm_oe_n, conv_start, conv_abort;
  wire cfg_shutdown, cfg_fault_queue, cfg_timeout_dis;
  wire [15:0] upper_limit, lower_limit, hysteresis;
  wire [6:0] adr = {ADDR_BASE[6:4], strap};
  // pull-up: low when either party pulls
  wire sda = m_sda & (sda_oe_n | sda_out);
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int aborts = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    aborts += conv_abort;
    if (cycles == 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  tss_master m (.scl(scl), .sda_drv(m_sda), .sda(sda));
  tss_slave #(.ALARM_VARIANT(1), .CONV_CYCLES(200), .TMO_CYCLES(300)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
    .addr_strap_bit2(strap[2]), .addr_strap_bit3(strap[3]), .conv_result(conv_result),
    .alarm_status(alarm_status), .alarm_req(alarm_req), .alarm_out(alarm_out),
    .alarm_oe_n(alarm_oe_n), .conv_start(conv_start), .conv_abort(conv_abort),
    .cfg_shutdown(cfg_shutdown), .cfg_fault_queue(cfg_fault_queue),
    .cfg_timeout_dis(cfg_timeout_dis), .upper_limit(upper_limit),
    .lower_limit(lower_limit), .hysteresis(hysteresis));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic head(input logic dir);
    m.start();
    m.xfer({adr, dir, 1'b1}, rx);
    chk("ack", 16'(rx[0]), 16'h0);
  endtask
  task automatic wr(input logic [2:0] ptr, input logic [15:0] d, input int n);
    head(1'b0);
    m.xfer({5'h0, ptr, 1'b1}, rx);
    for (int i = 0; i < n; i++) begin
      m.xfer({d[15-8*i -: 8], 1'b1}, rx);
    end
    m.stop();
  endtask
  // read word; the pointer is sent only when asked
  task automatic rd(input logic set, input logic [2:0] ptr);
    if (set) begin
      head(1'b0);
      m.xfer({5'h0, ptr, 1'b1}, rx);
    end
    head(1'b1);
    m.xfer({8'hFF, 1'b0}, rx);
    q[15:8] = rx[8:1];
    m.xfer({8'hFF, 1'b1}, rx);
    q[7:0] = rx[8:1];
    m.stop();
  endtask
  task automatic t_miss();
    m.start();
    m.xfer({adr ^ 7'h40, 2'b01}, rx);
    m.stop();
    chk("miss", 16'(rx[0]), 16'h1);
  endtask
  task automatic t_cfg();
    wr(PTR_CFG, 16'h9100, 1);
    chk("cfg bits", 16'({cfg_timeout_dis, cfg_fault_queue, cfg_shutdown}), 16'h7);
    rd(1'b1, PTR_CFG);
    chk("cfg", q, 16'h9100);
    rd(1'b0, PTR_CFG);
    chk("cfg again", q, 16'h9100);
    wr(PTR_CFG, 16'h0000, 1);
    chk("cfg clear", 16'(cfg_shutdown), 16'h0);
  endtask
  task automatic t_lim();
    wr(PTR_HYST, 16'h1357, 2);
    wr(PTR_LOW, 16'h2468, 2);
    wr(PTR_HIGH, 16'h7FF0, 2);
    wr(PTR_LOW, 16'hAB00, 1);
    chk("hyst", hysteresis, 16'h1357);
    chk("low", lower_limit, 16'hAB68);
    chk("high", upper_limit, 16'h7FF0);
    rd(1'b1, PTR_HIGH);
    chk("high rd", q, 16'h7FF0);
  endtask
  // hold the clock low mid-read; a stalled slave must let go of the data line
  task automatic t_tmo();
    head(1'b1);
    #1000;
    chk("stall held", 16'(sda), 16'h0);
    #700;
    chk("stall freed", 16'(sda), 16'h1);
    m.stop();
  endtask
  // the ignored write also spans several conversion periods
  task automatic t_temp();
    int n;
    @(posedge ref_clk);
    conv_result <= 13'h0F0F;
    wr(PTR_TEMP, 16'h5555, 2);
    n = aborts;
    rd(1'b1, PTR_TEMP);
    chk("temp", q, {13'h0F0F, 1'b0, alarm_status});
    chk("abort", 16'(aborts - n), 16'h1);
  endtask
  task automatic t_alarm();
    @(posedge ref_clk);
    alarm_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("alarm on", 16'(alarm_oe_n), 16'h0);
    alarm_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("alarm off", 16'(alarm_oe_n), 16'h1);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_miss();
    t_cfg();
    t_lim();
    t_tmo();
    t_temp();
    t_alarm();
    end_of_test();
  end
endmodule
